// ### core/adx_datapath.sv
// accumulator dot-subtract and fixed bitfield extract datapath with its own accumulators,
// control register and an AHB-Lite register slave
// assumes clk_in at 100 MHz, a single AHB master, and one issued word per enabled cycle
`timescale 1ns/10ps
`default_nettype none

// Contract
// - low byte-pair dot subtract: unsigned byte products of 15..8 and 7..0, zero-extended
// - cross subtract: high times low halfwords plus low times high halfwords, signed
// - two-bit select picks one of four accumulator pairs, 0 is the original pair
// - cross subtract leaves the overflow flag field untouched
// - cross subtract decodes as 011111, minor 01001, function 110000, select at 12..11
// - plain extract decodes as 011111, minor 00010, function 111000, size 25..21, dest 20..16
// - stepping extract decodes as 011111, minor 01010, function 111000, same fields
// - start index is control bits 5..0; bit 6 is ignored
// - extract size+1 bits from start index down to start index minus size
// - valid only when start minus (size+1) is at least -1, else failed
// - every extract writes the fail flag at bit 14: 1 failed, 0 succeeded
// - plain extract zero-extends to 32 bits then copies bit 31 upward
// - plain extract leaves the seven position bits unchanged
// - extracts never change the selected accumulator pair
// - stepping extract zero-extends to the full 64 bits
// - valid stepping extract subtracts size+1 from position bits 6..0
// - failed stepping extract keeps position bits, still sets the fail flag
// - no exception depends on operand values
// - reserved exception if absent, disabled exception if off; effects suppressed
module adx_datapath #(
  parameter bit EXT_PRESENT = 1'b1
) (
  // clock, reset, enable
  input  wire logic                clk_in,
  input  wire logic                resetn_in,
  input  wire logic                clk_en_in,
  // issue from the pipeline
  input  wire adx_pkg::adx_issue_s issue_in,
  // result back to the pipeline
  output var  adx_pkg::adx_result_s result_out,
  // ahb-lite slave
  input  wire logic                hsel_in,
  input  wire logic [31:0]         haddr_in,
  input  wire logic [1:0]          htrans_in,
  input  wire logic                hwrite_in,
  input  wire logic [2:0]          hsize_in,
  input  wire logic [31:0]         hwdata_in,
  input  wire logic                hready_in,
  output logic [31:0]              hrdata_out,
  output logic                     hreadyout_out,
  output logic                     hresp_out
);

  typedef struct packed {
    logic [1:0]             rst_sync;
    logic [31:0]            ctrl;
    logic                   cfg_en;
    logic [3:0][63:0]       upper;
    logic [3:0][63:0]       lower;
    adx_pkg::adx_result_s   res;
    logic                   dph_wr;
    logic [7:0]             dph_addr;
    logic [31:0]            rdata;
    logic                   ready;
  } adx_state_s;

  adx_state_s       st_q;
  adx_state_s       st_d;
  logic             rstn;

  // decoded issue
  adx_pkg::adx_op_e op;
  logic [1:0]       acsel;
  logic [4:0]       size;
  logic [4:0]       dest;
  logic [5:0]       start_pos;
  logic             ext_ok;
  logic [63:0]      acc_cat;
  logic [63:0]      field;
  logic [16:0]      dot_u;
  logic [32:0]      dot_s;
  logic [63:0]      diff;
  logic             go;
  logic             bus_wr_ctrl;
  logic             bus_wr_acc;

  assign rstn = st_q.rst_sync[1];

  function automatic logic [31:0] rd_word(input adx_state_s s, input logic [7:0] a);
    logic [7:0] rel;
    logic [1:0] n;
    rel = a - adx_pkg::OFF_ACC_BASE;
    n   = rel[5:4];
    rd_word = 32'h0000_0000;
    if (a == adx_pkg::OFF_CTRL) begin
      rd_word = s.ctrl;
    end else if (a == adx_pkg::OFF_CFG) begin
      rd_word[adx_pkg::CFG_EN_BIT] = s.cfg_en;
    end else if (a >= adx_pkg::OFF_ACC_BASE && a < adx_pkg::OFF_ACC_END) begin
      unique case (rel[3:2])
        2'h0: rd_word = s.lower[n][31:0];
        2'h1: rd_word = s.lower[n][63:32];
        2'h2: rd_word = s.upper[n][31:0];
        2'h3: rd_word = s.upper[n][63:32];
      endcase
    end
  endfunction

  // decode
  always_comb begin
    op = adx_pkg::OP_NONE;
    if (issue_in.word[31:adx_pkg::MAJOR_LSB] == adx_pkg::MAJOR_OPCODE_GROUP) begin
      if (issue_in.word[5:adx_pkg::FUNC_LSB] == adx_pkg::FUNC_DOT) begin
        if (issue_in.word[10:adx_pkg::MINOR_LSB] == adx_pkg::MINOR_DOT_LOW) begin
          op = adx_pkg::OP_DOT_LOW;
        end else if (issue_in.word[10:adx_pkg::MINOR_LSB] == adx_pkg::MINOR_CROSS) begin
          op = adx_pkg::OP_CROSS;
        end
      end else if (issue_in.word[5:adx_pkg::FUNC_LSB] == adx_pkg::FUNC_EXT) begin
        if (issue_in.word[10:adx_pkg::MINOR_LSB] == adx_pkg::MINOR_EXT) begin
          op = adx_pkg::OP_EXT;
        end else if (issue_in.word[10:adx_pkg::MINOR_LSB] == adx_pkg::MINOR_EXT_STEP) begin
          op = adx_pkg::OP_EXT_STEP;
        end
      end
    end
  end

  assign acsel = issue_in.word[12:adx_pkg::ACSEL_LSB];
  assign size  = issue_in.word[25:adx_pkg::SIZE_LSB];
  assign dest  = issue_in.word[20:adx_pkg::DEST_LSB];

  // effects only when present and enabled; nothing here looks at operand values
  assign go = clk_en_in && issue_in.valid && (op != adx_pkg::OP_NONE)
              && EXT_PRESENT && st_q.cfg_en;

  // arithmetic
  always_comb begin
    logic signed [31:0] prod_b;
    logic signed [31:0] prod_a;
    logic [5:0]         lsb;
    lsb    = 6'h00;
    prod_b = $signed(issue_in.source_one[31:16]) * $signed(issue_in.second_source_or_dest[15:0]);
    prod_a = $signed(issue_in.source_one[15:0]) * $signed(issue_in.second_source_or_dest[31:16]);
    acc_cat = {st_q.upper[acsel][31:0], st_q.lower[acsel][31:0]};
    dot_u = {9'h000, issue_in.source_one[15:8]} * {9'h000, issue_in.second_source_or_dest[15:8]}
            + {9'h000, issue_in.source_one[7:0]}
              * {9'h000, issue_in.second_source_or_dest[7:0]};
    dot_s = {prod_b[31], prod_b} + {prod_a[31], prod_a};
    if (op == adx_pkg::OP_CROSS) begin
      diff = acc_cat - {{31{dot_s[32]}}, dot_s};
    end else begin
      diff = acc_cat - {47'h0, dot_u};
    end
    start_pos = st_q.ctrl[adx_pkg::POS_LSB +: 6];
    ext_ok    = start_pos >= {1'b0, size};
    lsb       = start_pos - {1'b0, size};
    field     = (acc_cat >> lsb) & ~(64'hffff_ffff_ffff_fffe << size);
  end

  // bus decode of the data-phase write
  assign bus_wr_ctrl = st_q.dph_wr && (st_q.dph_addr == adx_pkg::OFF_CTRL);
  assign bus_wr_acc  = st_q.dph_wr && (st_q.dph_addr >= adx_pkg::OFF_ACC_BASE)
                       && (st_q.dph_addr < adx_pkg::OFF_ACC_END);

  always_comb begin
    logic [7:0] rel;
    logic [1:0] n;
    logic [6:0] pos_step;
    st_d          = st_q;
    rel           = st_q.dph_addr - adx_pkg::OFF_ACC_BASE;
    n             = rel[5:4];
    pos_step      = st_q.ctrl[adx_pkg::POS_LSB +: 7] - ({2'b00, size} + 7'h01);
    st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
    st_d.res      = '0;
    st_d.ready    = 1'b1;

    // data phase: the write lands first so that a read right behind it sees it
    if (st_q.dph_wr) begin
      if (st_q.dph_addr == adx_pkg::OFF_CTRL) begin
        st_d.ctrl = hwdata_in;
      end else if (st_q.dph_addr == adx_pkg::OFF_CFG) begin
        st_d.cfg_en = hwdata_in[adx_pkg::CFG_EN_BIT];
      end else if (bus_wr_acc) begin
        unique case (rel[3:2])
          2'h0: st_d.lower[n][31:0]  = hwdata_in;
          2'h1: st_d.lower[n][63:32] = hwdata_in;
          2'h2: st_d.upper[n][31:0]  = hwdata_in;
          2'h3: st_d.upper[n][63:32] = hwdata_in;
        endcase
      end
    end

    // address phase; zero wait states, always OKAY
    st_d.dph_wr = 1'b0;
    if (hsel_in && htrans_in[1] && hready_in) begin
      st_d.dph_wr   = hwrite_in && (haddr_in[31:8] == 24'h0);
      st_d.dph_addr = haddr_in[7:0];
      if (!hwrite_in) begin
        st_d.rdata = (haddr_in[31:8] == 24'h0) ? rd_word(st_d, haddr_in[7:0]) : 32'h0;
      end
    end

    // instruction; its updates override a bus write in the same cycle
    if (clk_en_in && issue_in.valid && (op != adx_pkg::OP_NONE)) begin
      st_d.res.valid        = 1'b1;
      st_d.res.dest         = dest;
      st_d.res.exc_reserved = !EXT_PRESENT;
      st_d.res.exc_disabled = EXT_PRESENT && !st_q.cfg_en;
    end
    if (go) begin
      unique case (op)
        adx_pkg::OP_DOT_LOW,
        adx_pkg::OP_CROSS: begin
          // overflow flags and the rest of the control word stay as they are
          st_d.upper[acsel] = {{32{diff[63]}}, diff[63:32]};
          st_d.lower[acsel] = {{32{diff[31]}}, diff[31:0]};
        end
        adx_pkg::OP_EXT: begin
          // a failed extract writes zero in place of an undefined value
          st_d.res.write = 1'b1;
          st_d.res.data  = ext_ok ? {{32{field[31]}}, field[31:0]} : 64'h0;
          st_d.ctrl[adx_pkg::FAIL_FLAG_BIT] = !ext_ok;
        end
        adx_pkg::OP_EXT_STEP: begin
          st_d.res.write = 1'b1;
          st_d.res.data  = ext_ok ? field : 64'h0;
          st_d.ctrl[adx_pkg::FAIL_FLAG_BIT] = !ext_ok;
          if (ext_ok) begin
            st_d.ctrl[adx_pkg::POS_LSB +: 7] = pos_step;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q          <= '0;
      st_q.ctrl     <= adx_pkg::CTRL_RST;
      st_q.cfg_en   <= adx_pkg::CFG_EN_RST;
      st_q.upper    <= {4{adx_pkg::ACC_RST}};
      st_q.lower    <= {4{adx_pkg::ACC_RST}};
      st_q.ready    <= 1'b1;
    end else if (!rstn) begin
      st_q.rst_sync <= st_d.rst_sync;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  assign result_out    = st_q.res;
  assign hrdata_out    = st_q.rdata;
  assign hreadyout_out = st_q.ready;
  assign hresp_out     = 1'b0;

  // checks
  property p_fail_flag;
    @(posedge clk_in) disable iff (!rstn)
    (go && (op == adx_pkg::OP_EXT || op == adx_pkg::OP_EXT_STEP))
      |=> (st_q.ctrl[adx_pkg::FAIL_FLAG_BIT] == !$past(ext_ok));
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("fail flag wrong");

  property p_ext_pos_kept;
    @(posedge clk_in) disable iff (!rstn)
    (go && op == adx_pkg::OP_EXT && !bus_wr_ctrl)
      |=> $stable(st_q.ctrl[6:0]);
  endproperty
  a_ext_pos_kept: assert property (p_ext_pos_kept) else $error("extract moved pos");

  property p_step_pos;
    @(posedge clk_in) disable iff (!rstn)
    (go && op == adx_pkg::OP_EXT_STEP && ext_ok)
      |=> (st_q.ctrl[6:0] == 7'($past(st_q.ctrl[6:0]) - $past(size) - 7'h01));
  endproperty
  a_step_pos: assert property (p_step_pos) else $error("pos not stepped");

  property p_step_fail_kept;
    @(posedge clk_in) disable iff (!rstn)
    (go && op == adx_pkg::OP_EXT_STEP && !ext_ok && !bus_wr_ctrl)
      |=> ($stable(st_q.ctrl[6:0]) && st_q.ctrl[adx_pkg::FAIL_FLAG_BIT]);
  endproperty
  a_step_fail_kept: assert property (p_step_fail_kept) else $error("failed step moved pos");

  property p_acc_kept;
    @(posedge clk_in) disable iff (!rstn)
    (go && (op == adx_pkg::OP_EXT || op == adx_pkg::OP_EXT_STEP) && !bus_wr_acc)
      |=> ($stable(st_q.upper) && $stable(st_q.lower));
  endproperty
  a_acc_kept: assert property (p_acc_kept) else $error("extract changed accumulator");

  property p_ext_sign;
    @(posedge clk_in) disable iff (!rstn)
    (go && op == adx_pkg::OP_EXT)
      |=> (result_out.valid && result_out.write
           && result_out.data[63:32] == {32{result_out.data[31]}});
  endproperty
  a_ext_sign: assert property (p_ext_sign) else $error("plain extract upper word");

  property p_step_zero;
    @(posedge clk_in) disable iff (!rstn)
    (go && op == adx_pkg::OP_EXT_STEP && size != 5'h1f)
      |=> (result_out.data[63:32] == 32'h0 && result_out.data[31] == 1'b0);
  endproperty
  a_step_zero: assert property (p_step_zero) else $error("step extract not zero-extended");

  property p_dot_low;
    @(posedge clk_in) disable iff (!rstn)
    (go && op == adx_pkg::OP_DOT_LOW && !bus_wr_acc)
      |=> (st_q.lower[$past(acsel)][31:0]
           == 32'($past(st_q.lower[acsel][31:0]) - {15'h0, $past(dot_u)}))
          && (st_q.lower[$past(acsel)][63:32] == {32{st_q.lower[$past(acsel)][31]}});
  endproperty
  a_dot_low: assert property (p_dot_low) else $error("dot subtract low word");

  property p_cross_flags;
    @(posedge clk_in) disable iff (!rstn)
    (go && op == adx_pkg::OP_CROSS && !bus_wr_ctrl)
      |=> $stable(st_q.ctrl[adx_pkg::SAT_FLAGS_LSB +: adx_pkg::SAT_FLAGS_W]);
  endproperty
  a_cross_flags: assert property (p_cross_flags) else $error("cross changed flags");

  property p_disabled;
    @(posedge clk_in) disable iff (!rstn)
    (clk_en_in && issue_in.valid && op != adx_pkg::OP_NONE && EXT_PRESENT
     && !st_q.cfg_en && !bus_wr_acc)
      |=> (result_out.exc_disabled && !result_out.write && $stable(st_q.upper));
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled not suppressed");

  property p_cross_word;
    @(posedge clk_in) disable iff (!rstn)
    (go && op == adx_pkg::OP_CROSS && !bus_wr_acc)
      |=> (st_q.lower[$past(acsel)][31:0] == 32'($past(acc_cat[31:0]) - $past(dot_s[31:0])))
          && (st_q.upper[$past(acsel)][63:32] == {32{st_q.upper[$past(acsel)][31]}});
  endproperty
  a_cross_word: assert property (p_cross_word) else $error("cross subtract word");

  // only reachable in a build without the extension
  property p_reserved;
    @(posedge clk_in) disable iff (!rstn)
    (clk_en_in && issue_in.valid && op != adx_pkg::OP_NONE && !EXT_PRESENT)
      |=> (result_out.exc_reserved && !result_out.write);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved not flagged");

  property p_no_exc;
    @(posedge clk_in) disable iff (!rstn)
    go |=> (result_out.valid && !result_out.exc_reserved && !result_out.exc_disabled);
  endproperty
  a_no_exc: assert property (p_no_exc) else $error("exception on enabled form");

  property p_unknown_word;
    @(posedge clk_in) disable iff (!rstn)
    (clk_en_in && issue_in.valid && op == adx_pkg::OP_NONE) |=> !result_out.valid;
  endproperty
  a_unknown_word: assert property (p_unknown_word) else $error("result for unknown word");

  // the top bit of the field lands at bit size of the result
  property p_ext_top_bit;
    @(posedge clk_in) disable iff (!rstn)
    (go && op == adx_pkg::OP_EXT_STEP && ext_ok)
      |=> (result_out.data[$past(size)] == $past(acc_cat[start_pos]));
  endproperty
  a_ext_top_bit: assert property (p_ext_top_bit) else $error("field top bit misplaced");

  property p_fail_zero;
    @(posedge clk_in) disable iff (!rstn)
    (go && (op == adx_pkg::OP_EXT || op == adx_pkg::OP_EXT_STEP) && !ext_ok)
      |=> (result_out.write && result_out.data == 64'h0);
  endproperty
  a_fail_zero: assert property (p_fail_zero) else $error("failed extract data");

endmodule

`default_nettype wire

// ### inc/adx_pkg.sv
// constants, types and layouts shared by the accumulator dot-subtract and extract datapath
// assumes a 32-bit AHB-Lite register port and a pipeline that issues one decoded word at a time
package adx_pkg;

  // instruction word fields
  localparam int unsigned MAJOR_LSB  = 26;
  localparam int unsigned SIZE_LSB   = 21;
  localparam int unsigned DEST_LSB   = 16;
  localparam int unsigned ACSEL_LSB  = 11;
  localparam int unsigned MINOR_LSB  = 6;
  localparam int unsigned FUNC_LSB   = 0;

  // major_opcode_group and minor/function codes
  localparam logic [5:0] MAJOR_OPCODE_GROUP = 6'h1f;
  localparam logic [4:0] MINOR_DOT_LOW      = 5'h0f;
  localparam logic [4:0] MINOR_CROSS        = 5'h09;
  localparam logic [5:0] FUNC_DOT           = 6'h30;
  localparam logic [4:0] MINOR_EXT          = 5'h02;
  localparam logic [4:0] MINOR_EXT_STEP     = 5'h0a;
  localparam logic [5:0] FUNC_EXT           = 6'h38;

  // signal_proc_control_reg fields
  localparam int unsigned POS_LSB     = 0;
  localparam int unsigned FAIL_FLAG_BIT = 14;
  localparam int unsigned SAT_FLAGS_LSB = 16;
  localparam int unsigned SAT_FLAGS_W   = 8;

  // register map (byte addresses)
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_CFG      = 8'h04;
  localparam logic [7:0] OFF_ACC_BASE = 8'h10;
  localparam logic [7:0] OFF_ACC_END  = 8'h50;
  localparam int unsigned CFG_EN_BIT  = 0;

  // reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic        CFG_EN_RST  = 1'b1;
  localparam logic [63:0] ACC_RST     = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_DOT_LOW,
    OP_CROSS,
    OP_EXT,
    OP_EXT_STEP
  } adx_op_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [63:0] source_one;
    logic [63:0] second_source_or_dest;
  } adx_issue_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  dest;
    logic [63:0] data;
    logic        exc_reserved;
    logic        exc_disabled;
  } adx_result_s;

endpackage

// ### test/accum_dotsub_bitextract_bench.sv
// self-checking bench: register traffic over ahb-lite, instructions through the pipe model
// assumes a zero-wait slave, though every wait is still bounded
`timescale 1ns/10ps
`default_nettype none
module accum_dotsub_bitextract_bench;
  logic                 clk_in;
  logic                 resetn_in;
  logic                 hwrite;
  logic [1:0]           htrans;
  logic [31:0]          haddr;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic [31:0]          rd;
  logic                 hreadyout;
  logic                 hresp;
  adx_pkg::adx_issue_s  issue;
  adx_pkg::adx_result_s res;
  int                   err_count;
  int                   total_checks;

  adx_datapath dut (.clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(1'b1),
    .issue_in(issue), .result_out(res), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp));
  adx_pipe_model pipe (.clk_in(clk_in), .issue_out(issue), .result_in(res));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) err_count++;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) err_count++;
    rd = hrdata;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk({31'h0, hresp, rd}, {32'h0, exp});
  endtask

  // extract flags: valid, write, destination 5
  task automatic xchk(input logic [63:0] d);
    chk({57'h0, pipe.got.valid, pipe.got.write, pipe.got.dest}, 64'h65);
    chk(pipe.got.data, d);
  endtask

  function automatic logic [31:0] mk(input logic [4:0] mi, input logic [5:0] fn,
                                     input logic [4:0] sz, input logic [1:0] sel);
    return {adx_pkg::MAJOR_OPCODE_GROUP, sz, 5'h05, 3'h0, sel, mi, fn};
  endfunction

  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    final_report();
  end

  initial begin
    resetn_in = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    err_count = 0;
    total_checks = 0;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rdc(32'h00, 32'h0);
    rdc(32'h04, 32'h1);
    rdc(32'h20, 32'h0);
    rdc(32'h80, 32'h0);
    // dot subtract on pair 1; upper words carry junk that must be ignored
    bus(1'b1, 32'h20, 32'h10);
    bus(1'b1, 32'h24, 32'h5555_5555);
    bus(1'b1, 32'h2c, 32'haaaa_aaaa);
    pipe.send(mk(adx_pkg::MINOR_DOT_LOW, adx_pkg::FUNC_DOT, 5'h0, 2'h1), 64'h80ff, 64'h02ff);
    chk(64'(pipe.got.valid), 64'h1);
    rdc(32'h20, 32'hffff_010f);
    rdc(32'h24, 32'hffff_ffff);
    rdc(32'h28, 32'hffff_ffff);
    rdc(32'h2c, 32'hffff_ffff);
    // cross subtract on pair 2 with a borrow out of the lower word into the upper word
    bus(1'b1, 32'h00, 32'h00ff_0000);
    bus(1'b1, 32'h30, 32'h1);
    bus(1'b1, 32'h38, 32'h1);
    pipe.send(mk(adx_pkg::MINOR_CROSS, adx_pkg::FUNC_DOT, 5'h0, 2'h2), 64'hffff_0002,
              64'h0003_0004);
    rdc(32'h30, 32'hffff_ffff);
    rdc(32'h34, 32'hffff_ffff);
    rdc(32'h38, 32'h0);
    rdc(32'h3c, 32'h0);
    rdc(32'h00, 32'h00ff_0000);
    // plain and stepping extracts; position bit 6 and a stale fail flag are set
    bus(1'b1, 32'h10, 32'h1234_5678);
    bus(1'b1, 32'h00, 32'h0000_404f);
    pipe.send(mk(adx_pkg::MINOR_EXT, adx_pkg::FUNC_EXT, 5'h7, 2'h0), 64'h0, 64'h0);
    xchk(64'h56);
    rdc(32'h00, 32'h4f);
    pipe.send(mk(adx_pkg::MINOR_EXT_STEP, adx_pkg::FUNC_EXT, 5'h7, 2'h0), 64'h0, 64'h0);
    xchk(64'h56);
    rdc(32'h00, 32'h47);
    // widest field at the lowest legal start
    bus(1'b1, 32'h10, 32'h8000_0000);
    bus(1'b1, 32'h00, 32'h1f);
    pipe.send(mk(adx_pkg::MINOR_EXT, adx_pkg::FUNC_EXT, 5'h1f, 2'h0), 64'h0, 64'h0);
    xchk(64'hffff_ffff_8000_0000);
    pipe.send(mk(adx_pkg::MINOR_EXT_STEP, adx_pkg::FUNC_EXT, 5'h1f, 2'h0), 64'h0, 64'h0);
    xchk(64'h8000_0000);
    rdc(32'h00, 32'h7f);
    // failed stepping extract keeps the position and raises the flag
    bus(1'b1, 32'h00, 32'h3);
    pipe.send(mk(adx_pkg::MINOR_EXT_STEP, adx_pkg::FUNC_EXT, 5'h4, 2'h0), 64'h0, 64'h0);
    chk(64'({pipe.got.valid, pipe.got.write}), 64'h3);
    rdc(32'h00, 32'h4003);
    rdc(32'h10, 32'h8000_0000);
    // extension switched off: flagged and without effect
    bus(1'b1, 32'h04, 32'h0);
    pipe.send(mk(adx_pkg::MINOR_CROSS, adx_pkg::FUNC_DOT, 5'h0, 2'h2), 64'h1, 64'h1);
    chk(64'({pipe.got.valid, pipe.got.write, pipe.got.exc_disabled}), 64'h5);
    rdc(32'h30, 32'hffff_ffff);
    bus(1'b1, 32'h04, 32'h1);
    // a word outside the four forms gives no result
    pipe.send(mk(5'h03, adx_pkg::FUNC_EXT, 5'h1, 2'h0), 64'h0, 64'h0);
    chk(64'(pipe.got.valid), 64'h0);
    pipe.send(mk(adx_pkg::MINOR_EXT, adx_pkg::FUNC_EXT, 5'h1, 2'h0), 64'h0, 64'h0);
    chk(64'({pipe.got.valid, pipe.got.exc_reserved}), 64'h2);
    final_report();
  end
endmodule
`default_nettype wire

// ### test/adx_pipe_model.sv
// pipeline side model: issues one decoded word and captures the answer
// assumes the datapath answers exactly one cycle after it takes an issue
`timescale 1ns/10ps
`default_nettype none
module adx_pipe_model (
  // clock
  input  wire logic                 clk_in,
  // issue and result
  output var  adx_pkg::adx_issue_s  issue_out,
  input  wire adx_pkg::adx_result_s result_in
);
  adx_pkg::adx_result_s got;

  initial issue_out = '0;

  // result stands one cycle, so it is taken at the edge after the issue edge
  task automatic send(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
    @(posedge clk_in);
    issue_out <= '{1'b1, w, a, b};
    @(posedge clk_in);
    issue_out.valid <= 1'b0;
    @(posedge clk_in);
    got = result_in;
  endtask
endmodule
`default_nettype wire
